// File: logic/oag_pkg.sv
// package for the operand address generator: modes, segment codes, widths
// assumes nothing beyond a systemverilog-2012 compiler
package oag_pkg;
  localparam int unsigned OFS_W      = 16;
  localparam int unsigned SEL_W      = 16;
  localparam int unsigned SEG_SPAN   = 65536;
  localparam logic [15:0] RESET_WORD = 16'h0000;

  typedef enum logic [3:0] {
    OAG_SEG_CODE  = 4'h1,
    OAG_SEG_STACK = 4'h2,
    OAG_SEG_DATA  = 4'h4,
    OAG_SEG_EXTRA = 4'h8
  } oag_seg_t;

  typedef enum logic [2:0] {
    OAG_AM_DIRECT   = 3'h0,
    OAG_AM_REG_IND  = 3'h1,
    OAG_AM_BASED    = 3'h2,
    OAG_AM_INDEXED  = 3'h3,
    OAG_AM_BASE_IDX = 3'h4,
    OAG_AM_BIDX_DSP = 3'h5,
    OAG_AM_REGISTER = 3'h6,
    OAG_AM_IMMED    = 3'h7
  } oag_mode_t;

  typedef enum logic [1:0] {
    OAG_REF_FETCH = 2'h0,
    OAG_REF_STACK = 2'h1,
    OAG_REF_DATA  = 2'h2,
    OAG_REF_SDEST = 2'h3
  } oag_ref_t;

  // register indirect picks one of four: 0 base gen, 1 base stack, 2 src idx, 3 dst idx
  localparam logic [1:0] IND_BASE_GEN   = 2'h0;
  localparam logic [1:0] IND_BASE_STACK = 2'h1;
  localparam logic [1:0] IND_SRC_IDX    = 2'h2;
  localparam logic [1:0] IND_DST_IDX    = 2'h3;

  typedef enum logic [1:0] {
    OAG_ST_IDLE  = 2'b01,
    OAG_ST_VALID = 2'b10
  } oag_state_t;
endpackage

// File: logic/oag_offset_adder.sv
// offset adder: optional displacement plus optional base plus optional index
// assumes operands already chosen by the caller; purely combinational
`timescale 1ns/1ps
`default_nettype none
module oag_offset_adder #(
  parameter int unsigned W = 16
) (
  input  wire logic [W-1:0] disp,
  input  wire logic         disp_byte,
  input  wire logic         use_disp,
  input  wire logic [W-1:0] base_val,
  input  wire logic         use_base,
  input  wire logic [W-1:0] index_val,
  input  wire logic         use_index,
  output logic      [W-1:0] sum
);
  logic [W-1:0] disp_ext;
  logic [W-1:0] b_term;
  logic [W-1:0] i_term;
  logic [W-1:0] d_term;

  always_comb begin
    disp_ext = disp_byte ? {{(W-8){disp[7]}}, disp[7:0]} : disp; // see RQ12
    d_term   = use_disp  ? disp_ext  : '0;
    b_term   = use_base  ? base_val  : '0;
    i_term   = use_index ? index_val : '0;
    sum      = W'(d_term + b_term + i_term); // carry dropped, wraps; see RQ11 see RQ10
  end
endmodule
`default_nettype wire

// File: logic/oag_top.sv
// operand address generator: segment choice plus offset formation
// assumes decoder drives one request per cycle with req_valid, fields stable that cycle
`timescale 1ns/1ps
`default_nettype none
// What this block does
// RQ1: segment offsets are 16 bits, 64K span
// RQ2: address is selector plus offset pair
// RQ3: prefetch always uses code segment
// RQ4: stack ops and stack base use stack
// RQ5: other data references use data segment
// RQ6: string destination uses extra segment
// RQ7: override prefix replaces implicit segment choice
// RQ8: register mode reads 8- or 16-bit general
// RQ9: immediate mode takes instruction value, no memory
// RQ10: offset sums displacement, base, index combos
// RQ11: offset sum wraps modulo 2^16
// RQ12: 8-bit displacement sign extended first
// RQ13: direct mode offset is displacement only
// RQ14: register indirect uses one register alone
// RQ15: based mode is displacement plus base
// RQ16: indexed mode is displacement plus index
// RQ17: based indexed sums base and index
// RQ18: based indexed displacement sums all three
// RQ19: selector and offset presented same cycle
module oag_top #(
  parameter int unsigned W = oag_pkg::OFS_W
) (
  input  wire logic                    core_clk,
  input  wire logic                    rst_b,
  input  wire logic                    req_valid,
  input  wire oag_pkg::oag_mode_t      req_mode,
  input  wire oag_pkg::oag_ref_t       req_ref,
  input  wire logic                    ovr_valid,
  input  wire oag_pkg::oag_seg_t       ovr_seg,
  input  wire logic [W-1:0]            disp,
  input  wire logic                    disp_byte,
  input  wire logic                    base_is_stack,
  input  wire logic                    index_is_dest,
  input  wire logic [1:0]              ind_sel,
  input  wire logic [W-1:0]            base_reg_general,
  input  wire logic [W-1:0]            base_reg_stack,
  input  wire logic [W-1:0]            src_index_reg,
  input  wire logic [W-1:0]            dest_index_reg,
  input  wire logic [W-1:0]            code_segment_reg,
  input  wire logic [W-1:0]            stack_segment_reg,
  input  wire logic [W-1:0]            data_segment_reg,
  input  wire logic [W-1:0]            extra_segment_reg,
  input  wire logic [2:0]              gen_reg_sel,
  input  wire logic                    gen_reg_byte,
  input  wire logic                    gen_reg_high,
  input  wire logic [8*W-1:0]          gen_regs,
  input  wire logic [W-1:0]            imm_value,
  output logic                         mem_valid,
  output logic [W-1:0]                 mem_selector,
  output logic [W-1:0]                 mem_offset,
  output oag_pkg::oag_seg_t            mem_seg,
  output logic                         opnd_valid,
  output logic [W-1:0]                 opnd_value
);
  oag_pkg::oag_state_t state_ff;
  oag_pkg::oag_state_t nxt_state;
  logic [W-1:0]        sel_ff;
  logic [W-1:0]        nxt_sel;
  logic [W-1:0]        ofs_ff;
  logic [W-1:0]        nxt_ofs;
  oag_pkg::oag_seg_t   seg_ff;
  oag_pkg::oag_seg_t   nxt_seg;
  logic                opv_ff;
  logic                nxt_opv;
  logic [W-1:0]        opd_ff;
  logic [W-1:0]        nxt_opd;

  logic                use_disp;
  logic                use_base;
  logic                use_index;
  logic [W-1:0]        base_val;
  logic [W-1:0]        index_val;
  logic [W-1:0]        sum;
  logic                is_mem;
  logic                stack_rel;
  oag_pkg::oag_seg_t   impl_seg;
  oag_pkg::oag_seg_t   eff_seg;
  logic [W-1:0]        gen_word;
  logic [W-1:0]        gen_val;

  // per-mode element enables and register steering
  always_comb begin
    use_disp  = 1'b0;
    use_base  = 1'b0;
    use_index = 1'b0;
    base_val  = base_is_stack ? base_reg_stack : base_reg_general;
    index_val = index_is_dest ? dest_index_reg : src_index_reg;
    is_mem    = 1'b1;
    case (req_mode)
      oag_pkg::OAG_AM_DIRECT: begin
        use_disp = 1'b1; // see RQ13
      end
      oag_pkg::OAG_AM_REG_IND: begin
        // one register through the base leg, nothing else added; see RQ14
        use_base = 1'b1;
        case (ind_sel)
          oag_pkg::IND_BASE_GEN:   base_val = base_reg_general;
          oag_pkg::IND_BASE_STACK: base_val = base_reg_stack;
          oag_pkg::IND_SRC_IDX:    base_val = src_index_reg;
          default:                 base_val = dest_index_reg;
        endcase
      end
      oag_pkg::OAG_AM_BASED: begin
        use_disp = 1'b1; // see RQ15
        use_base = 1'b1;
      end
      oag_pkg::OAG_AM_INDEXED: begin
        use_disp  = 1'b1; // see RQ16
        use_index = 1'b1;
      end
      oag_pkg::OAG_AM_BASE_IDX: begin
        use_base  = 1'b1; // see RQ17
        use_index = 1'b1;
      end
      oag_pkg::OAG_AM_BIDX_DSP: begin
        use_disp  = 1'b1; // see RQ18
        use_base  = 1'b1;
        use_index = 1'b1;
      end
      default: begin
        is_mem = 1'b0; // register and immediate modes make no memory access; see RQ9
      end
    endcase
  end

  // 16-bit wrap keeps the offset inside one 64K segment; see RQ1
  oag_offset_adder #(
    .W (W)
  ) u_adder (
    .disp      (disp),
    .disp_byte (disp_byte),
    .use_disp  (use_disp),
    .base_val  (base_val),
    .use_base  (use_base),
    .index_val (index_val),
    .use_index (use_index),
    .sum       (sum)
  );

  // implicit segment choice, then override
  always_comb begin
    stack_rel = 1'b0;
    if (req_mode == oag_pkg::OAG_AM_REG_IND) begin
      stack_rel = (ind_sel == oag_pkg::IND_BASE_STACK);
    end else if (use_base) begin
      stack_rel = base_is_stack;
    end
    case (req_ref)
      oag_pkg::OAG_REF_FETCH: impl_seg = oag_pkg::OAG_SEG_CODE;  // see RQ3
      oag_pkg::OAG_REF_STACK: impl_seg = oag_pkg::OAG_SEG_STACK; // see RQ4
      oag_pkg::OAG_REF_SDEST: impl_seg = oag_pkg::OAG_SEG_EXTRA; // see RQ6
      default: impl_seg = stack_rel ? oag_pkg::OAG_SEG_STACK     // see RQ4
                                    : oag_pkg::OAG_SEG_DATA;     // see RQ5
    endcase
    // prefetch ignores prefixes; the override is an operand-only thing
    eff_seg = impl_seg;
    if (ovr_valid && req_ref != oag_pkg::OAG_REF_FETCH) begin
      eff_seg = ovr_seg; // see RQ7
    end
  end

  // general register read: word or one byte half; see RQ8
  always_comb begin
    gen_word = gen_regs[gen_reg_sel*W +: W];
    if (gen_reg_byte) begin
      gen_val = gen_reg_high ? {8'h00, gen_word[15:8]} : {8'h00, gen_word[7:0]};
    end else begin
      gen_val = gen_word;
    end
  end

  // next-state: selector and offset loaded together; see RQ19 see RQ2
  always_comb begin
    nxt_state = oag_pkg::OAG_ST_IDLE;
    nxt_sel   = sel_ff;
    nxt_ofs   = ofs_ff;
    nxt_seg   = seg_ff;
    nxt_opv   = 1'b0;
    nxt_opd   = opd_ff;
    case (state_ff)
      oag_pkg::OAG_ST_IDLE, oag_pkg::OAG_ST_VALID: begin
        if (req_valid && is_mem) begin
          nxt_state = oag_pkg::OAG_ST_VALID;
          nxt_seg   = eff_seg;
          nxt_ofs   = sum;
          case (eff_seg)
            oag_pkg::OAG_SEG_CODE:  nxt_sel = code_segment_reg;
            oag_pkg::OAG_SEG_STACK: nxt_sel = stack_segment_reg;
            oag_pkg::OAG_SEG_EXTRA: nxt_sel = extra_segment_reg;
            default:                nxt_sel = data_segment_reg;
          endcase
        end else if (req_valid) begin
          nxt_opv = 1'b1;
          nxt_opd = (req_mode == oag_pkg::OAG_AM_IMMED) ? imm_value : gen_val; // see RQ9 see RQ8
        end
      end
      default: begin
        nxt_state = oag_pkg::OAG_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_ff <= oag_pkg::OAG_ST_IDLE;
      sel_ff   <= oag_pkg::RESET_WORD;
      ofs_ff   <= oag_pkg::RESET_WORD;
      seg_ff   <= oag_pkg::OAG_SEG_DATA;
      opv_ff   <= 1'b0;
      opd_ff   <= oag_pkg::RESET_WORD;
    end else begin
      state_ff <= nxt_state;
      sel_ff   <= nxt_sel;
      ofs_ff   <= nxt_ofs;
      seg_ff   <= nxt_seg;
      opv_ff   <= nxt_opv;
      opd_ff   <= nxt_opd;
    end
  end

  assign mem_valid    = (state_ff == oag_pkg::OAG_ST_VALID);
  assign mem_selector = sel_ff;
  assign mem_offset   = ofs_ff;
  assign mem_seg      = seg_ff;
  assign opnd_valid   = opv_ff;
  assign opnd_value   = opd_ff;
endmodule
`default_nettype wire

// File: bench/oag_top_props.sv
// checker for the operand address generator, watching top ports only
// assumes binding into oag_top, single clock domain
`timescale 1ns/1ps
`default_nettype none
module oag_top_props #(
  parameter int unsigned W = 16
) (
  input wire logic              core_clk,
  input wire logic              rst_b,
  input wire logic              req_valid,
  input wire oag_pkg::oag_mode_t req_mode,
  input wire oag_pkg::oag_ref_t  req_ref,
  input wire logic              ovr_valid,
  input wire oag_pkg::oag_seg_t  ovr_seg,
  input wire logic [W-1:0]      disp,
  input wire logic              disp_byte,
  input wire logic [W-1:0]      code_segment_reg,
  input wire logic [W-1:0]      extra_segment_reg,
  input wire logic [W-1:0]      imm_value,
  input wire logic              mem_valid,
  input wire logic [W-1:0]      mem_selector,
  input wire logic [W-1:0]      mem_offset,
  input wire oag_pkg::oag_seg_t  mem_seg,
  input wire logic              opnd_valid,
  input wire logic [W-1:0]      opnd_value
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  sequence s_mem_req;
    req_valid && req_mode < oag_pkg::OAG_AM_REGISTER;
  endsequence
  sequence s_own;
    s_mem_req ##0 !ovr_valid;
  endsequence
  chk_fetch_code: assert property (s_mem_req ##0 req_ref == oag_pkg::OAG_REF_FETCH |=>
    mem_seg == oag_pkg::OAG_SEG_CODE && mem_selector == $past(code_segment_reg))
    else $error("fetch did not use code segment");
  chk_stack_ref: assert property (s_own ##0 req_ref == oag_pkg::OAG_REF_STACK |=>
    mem_seg == oag_pkg::OAG_SEG_STACK) else $error("stack ref segment wrong");
  chk_dest_extra: assert property (s_own ##0 req_ref == oag_pkg::OAG_REF_SDEST |=>
    mem_seg == oag_pkg::OAG_SEG_EXTRA && mem_selector == $past(extra_segment_reg))
    else $error("string destination segment wrong");
  chk_data_dflt: assert property (s_own ##0 req_ref == oag_pkg::OAG_REF_DATA ##0
    req_mode == oag_pkg::OAG_AM_DIRECT |=> mem_seg == oag_pkg::OAG_SEG_DATA)
    else $error("data ref segment wrong");
  chk_ovr_used: assert property (s_mem_req ##0 ovr_valid && req_ref != oag_pkg::OAG_REF_FETCH
    |=> mem_seg == $past(ovr_seg)) else $error("override ignored");
  chk_imm_nomem: assert property (req_valid && req_mode == oag_pkg::OAG_AM_IMMED |=>
    !mem_valid && opnd_valid && opnd_value == $past(imm_value)) else $error("immediate wrong");
  chk_direct_ofs: assert property (s_mem_req ##0 req_mode == oag_pkg::OAG_AM_DIRECT
    && !disp_byte |=> mem_offset == $past(disp)) else $error("direct offset wrong");
  chk_sign_ext: assert property (s_mem_req ##0 req_mode == oag_pkg::OAG_AM_DIRECT
    && disp_byte |=> mem_offset == {{8{$past(disp[7])}}, $past(disp[7:0])})
    else $error("byte displacement not sign extended");
  chk_mem_pulse: assert property (s_mem_req ##1 !req_valid |-> mem_valid ##1 !mem_valid)
    else $error("memory valid not a single cycle");
endmodule
bind oag_top oag_top_props #(.W(W)) u_props (.*);
`default_nettype wire

// File: bench/oag_xlat_sink.sv
// translation-side sink: counts selector and offset pairs handed over
// assumes one pair per cycle of mem_valid, no back-pressure
`timescale 1ns/1ps
`default_nettype none
module oag_xlat_sink (
  input  wire logic  core_clk,
  input  wire logic  rst_b,
  input  wire logic  mem_valid,
  output int unsigned mem_count
);
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) mem_count <= 0;
    else if (mem_valid) mem_count <= mem_count + 1;
  end
endmodule
`default_nettype wire

// File: bench/test_operand_address_generator.sv
// random back-to-back requests checked against an integer model
// assumes one cycle latency and outputs settled 1 ns after the edge
`timescale 1ns/1ps
`default_nettype none
module test_operand_address_generator;
  logic core_clk, rst_b, req_valid, ovr_valid, disp_byte, base_is_stack, index_is_dest;
  logic gen_reg_byte, gen_reg_high, mem_valid, opnd_valid, e_mem, e_opv;
  oag_pkg::oag_mode_t req_mode;
  oag_pkg::oag_ref_t req_ref;
  oag_pkg::oag_seg_t ovr_seg, mem_seg, e_seg;
  logic [1:0] ind_sel;
  logic [2:0] gen_reg_sel;
  logic [127:0] gen_regs;
  logic [15:0] disp, base_reg_general, base_reg_stack, src_index_reg, dest_index_reg;
  logic [15:0] code_segment_reg, stack_segment_reg, data_segment_reg, extra_segment_reg;
  logic [15:0] imm_value, mem_selector, mem_offset, opnd_value, e_ofs, e_sel, e_val, w;
  int num_errors = 0, compares = 0, n_mem = 0, d, b, x, o, r[4];
  int unsigned mem_count;
  oag_top DUT (.*);
  oag_xlat_sink u_sink (.core_clk(core_clk), .rst_b(rst_b), .mem_valid(mem_valid),
    .mem_count(mem_count));
  task automatic cmp_word(input logic [15:0] g, input logic [15:0] e);
    compares++;
    if (g !== e) begin
      num_errors++;
      $display("unexpected at %0t: got %h exp %h", $time, g, e);
    end
  endtask
  task automatic cmp_bit(input logic g, input logic e);
    cmp_word({15'h0, g}, {15'h0, e});
  endtask
  task automatic drive(input logic v);
    req_valid <= v;
    req_mode <= oag_pkg::oag_mode_t'($urandom_range(7, 0));
    req_ref <= oag_pkg::oag_ref_t'($urandom_range(3, 0));
    ovr_seg <= oag_pkg::oag_seg_t'(4'h1 << $urandom_range(3, 0));
    {ovr_valid, disp_byte, base_is_stack, index_is_dest, gen_reg_byte, gen_reg_high} <= 6'($urandom);
    {ind_sel, gen_reg_sel} <= 5'($urandom);
    gen_regs <= {$urandom, $urandom, $urandom, $urandom};
    {disp, base_reg_general, base_reg_stack, src_index_reg} <= {$urandom, $urandom};
    {dest_index_reg, code_segment_reg, stack_segment_reg} <= 48'({$urandom, $urandom});
    {data_segment_reg, extra_segment_reg, imm_value} <= 48'({$urandom, $urandom});
  endtask
  task automatic model();
    d = disp_byte ? {{8{disp[7]}}, disp[7:0]} : disp;
    r = '{base_reg_general, base_reg_stack, src_index_reg, dest_index_reg};
    b = base_is_stack ? base_reg_stack : base_reg_general;
    x = index_is_dest ? dest_index_reg : src_index_reg;
    case (int'(req_mode))
      0: o = d;
      1: o = r[ind_sel];
      2: o = d + b;
      3: o = d + x;
      4: o = b + x;
      default: o = b + x + d;
    endcase
    e_ofs = 16'(o % oag_pkg::SEG_SPAN);
    if (req_ref == oag_pkg::OAG_REF_FETCH) e_seg = oag_pkg::OAG_SEG_CODE;
    else if (ovr_valid) e_seg = ovr_seg;
    else if (req_ref == oag_pkg::OAG_REF_STACK) e_seg = oag_pkg::OAG_SEG_STACK;
    else if (req_ref == oag_pkg::OAG_REF_SDEST) e_seg = oag_pkg::OAG_SEG_EXTRA;
    else if ((int'(req_mode) inside {2, 4, 5} && base_is_stack) || (int'(req_mode) == 1
      && ind_sel == 2'h1)) e_seg = oag_pkg::OAG_SEG_STACK;
    else e_seg = oag_pkg::OAG_SEG_DATA;
    case (e_seg)
      oag_pkg::OAG_SEG_CODE: e_sel = code_segment_reg;
      oag_pkg::OAG_SEG_STACK: e_sel = stack_segment_reg;
      oag_pkg::OAG_SEG_EXTRA: e_sel = extra_segment_reg;
      default: e_sel = data_segment_reg;
    endcase
    w = gen_regs[16*gen_reg_sel +: 16];
    e_val = !req_mode[0] ? (gen_reg_byte ? {8'h0, gen_reg_high ? w[15:8] : w[7:0]} : w) : imm_value;
    e_mem = req_valid && req_mode < oag_pkg::OAG_AM_REGISTER;
    e_opv = req_valid && req_mode >= oag_pkg::OAG_AM_REGISTER;
  endtask
  task automatic check();
    cmp_bit(mem_valid, e_mem);
    cmp_bit(opnd_valid, e_opv);
    if (e_mem) begin
      n_mem++;
      cmp_word(mem_offset, e_ofs);
      cmp_word(mem_selector, e_sel);
      cmp_word({12'h0, mem_seg}, {12'h0, e_seg});
    end
    if (e_opv) cmp_word(opnd_value, e_val);
  endtask
  task automatic summarize();
    $display("compares %0d errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  initial begin
    #10000;
    num_errors++;
    summarize();
  end
  initial begin
    rst_b = 1'b0;
    void'($urandom(32'ha9d0));
    drive(1'b0);
    repeat (20) @(posedge core_clk);
    cmp_bit(mem_valid, 1'b0);
    cmp_word({12'h0, mem_seg}, {12'h0, oag_pkg::OAG_SEG_DATA});
    $display("test reset done");
    rst_b <= 1'b1;
    {e_mem, e_opv} = 2'b00;
    // idle cycles mixed in so single-cycle valid pulses are seen
    repeat (400) begin
      @(posedge core_clk);
      drive($urandom_range(3, 0) != 0);
      #1;
      check();
      model();
    end
    @(posedge core_clk);
    drive(1'b0);
    #1;
    check();
    // the sink only counts the last pulse at the edge that ends it
    @(posedge core_clk);
    #1;
    cmp_word(16'(mem_count), 16'(n_mem));
    $display("test random done");
    summarize();
  end
endmodule
`default_nettype wire
